// ===== verilog/ssl_top.sv
// serial programming latches and digital lock indicator of the synthesizer
//
// Operation
// R1 - shift one bit per rising serial clock
// R2 - host sends bit 23 first, bit 0 last
// R3 - load strobe rise copies word into latch
// R4 - bits 1 and 0 choose the latch
// R5 - 00 ref, 01 feedback, 10 function, 11 startup
// R6 - reference divide value in bits 15..2
// R7 - bits 17..16 set backlash pulse width
// R8 - bit 20 precision, 19..18 test, 23 ignored
// R9 - gain 21, main count 20..8, swallow 7..2
// R10 - function/startup: modulus, power, currents, timer
// R11 - fastlock, tristate, polarity, power-down, counter reset
// R12 - output select bits 6..4 drive test output
// R13 - digital lock active high, routable to output
// R14 - precision 0: three good cycles lock
// R15 - precision 1: five good cycles lock
// R16 - lock holds until error above 25 ns
// R17 - reference divide usable 1 to 16383
// R18 - host keeps main count 3 to 8191
// R19 - unlocked: bad cycle restarts good count
// R20 - loading one latch leaves others unchanged
`timescale 1ns/100ps
`default_nettype none
`include "ssl_cfg.svh"
module ssl_top #(
  parameter int WORD_W = 24,
  parameter int ERR_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_i,
  input wire logic load_strobe_i,
  input wire logic pd_cycle_i,
  input wire logic [ERR_W-1:0] phase_error_ns_i,
  input wire logic ref_div_out_i,
  input wire logic feedback_div_out_i,
  input wire logic analog_lock_i,
  output logic [WORD_W-1:0] reference_divider_word_o,
  output logic [WORD_W-1:0] feedback_divider_word_o,
  output logic [WORD_W-1:0] function_word_o,
  output logic [WORD_W-1:0] startup_setup_word_o,
  output logic [3:0] latch_loaded_o,
  output logic [13:0] ref_divide_o,
  output logic [1:0] backlash_width_o,
  output logic [1:0] test_sel_o,
  output logic lock_precision_o,
  output logic pump_gain_select_o,
  output logic [12:0] main_count_o,
  output logic [5:0] swallow_count_o,
  output logic [1:0] modulus_sel_o,
  output logic power_down_two_o,
  output logic [2:0] pump_current_b_o,
  output logic [2:0] pump_current_a_o,
  output logic [3:0] fastlock_timer_o,
  output logic fastlock_mode_o,
  output logic fastlock_enable_o,
  output logic pump_tristate_o,
  output logic phase_polarity_o,
  output logic [2:0] output_select_o,
  output logic power_down_one_o,
  output logic divider_reset_o,
  output logic digital_lock_o,
  output logic multiplexed_test_output_o
);

  // ==================================================================
  // elaboration checks
  if (WORD_W != `SSL_WORD_W) begin : g_word_chk
    $error("ssl_top: field layout needs a 24-bit word");
  end

  // ==================================================================
  // link domain: input shift register on the serial clock
  ssl_pkg::ssl_link_s link;
  ssl_pkg::ssl_link_s next_link;

  always_comb begin
    next_link = link;
    // first bit in ends up at the top after 24 edges
    next_link.shift = {link.shift[WORD_W-2:0], serial_data_i}; // R1 R2
  end

  always_ff @(posedge serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      link <= '0;
    end else begin
      link <= next_link; // R1
    end
  end

  // ==================================================================
  // load strobe into the core clock domain
  logic load_level;
  logic load_rise;

  ssl_sync u_load_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(load_strobe_i),
    .level_o(load_level)
  );

  // ==================================================================
  // core domain state
  ssl_pkg::ssl_core_s core;
  ssl_pkg::ssl_core_s next_core;
  ssl_pkg::ssl_latch_e sel;
  logic [WORD_W-1:0] active;
  logic [2:0] osel;
  logic lock_flag;

  assign load_rise = load_level & ~core.load_prev; // R3
  // shift word is quiet here: the serial clock stops before the strobe
  assign sel = ssl_pkg::ssl_latch_e'(link.shift[`SSL_SEL_LSB +: 2]); // R4
  // settings follow whichever of function or startup came last
  assign active = core.use_startup ? core.startup : core.function_w;
  assign osel = active[`SSL_OUTPUT_SEL_LSB +: 3];

  always_comb begin
    next_core = core;
    next_core.load_prev = load_level;
    next_core.loaded = 4'h0;
    if (load_rise) begin
      // only the selected latch is written
      unique case (sel) // R5 R20
        ssl_pkg::ssl_sel_reference: begin
          next_core.reference = link.shift; // R3
          next_core.loaded = 4'h1;
        end
        ssl_pkg::ssl_sel_feedback: begin
          next_core.feedback = link.shift;
          next_core.loaded = 4'h2;
        end
        ssl_pkg::ssl_sel_function: begin
          next_core.function_w = link.shift;
          next_core.use_startup = 1'b0;
          next_core.loaded = 4'h4;
        end
        ssl_pkg::ssl_sel_startup: begin
          next_core.startup = link.shift;
          next_core.use_startup = 1'b1;
          next_core.loaded = 4'h8;
        end
      endcase
    end
    // unlisted codes park the output low
    case (osel) // R12
      `SSL_OSEL_DIGITAL_LOCK: next_core.mux_out = lock_flag; // R13
      `SSL_OSEL_FEEDBACK_DIV: next_core.mux_out = feedback_div_out_i;
      `SSL_OSEL_HIGH: next_core.mux_out = 1'b1;
      `SSL_OSEL_REF_DIV: next_core.mux_out = ref_div_out_i;
      `SSL_OSEL_ANALOG_LOCK: next_core.mux_out = analog_lock_i; // R13
      default: next_core.mux_out = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  // ==================================================================
  // lock detector
  ssl_lock #(
    .ERR_W(ERR_W)
  ) u_lock (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pd_cycle_i(pd_cycle_i),
    .phase_error_ns_i(phase_error_ns_i),
    .lock_precision_i(core.reference[`SSL_LOCK_PRECISION_BIT]),
    .digital_lock_o(lock_flag)
  );

  // ==================================================================
  // raw words and load pulses
  assign reference_divider_word_o = core.reference;
  assign feedback_divider_word_o = core.feedback;
  assign function_word_o = core.function_w;
  assign startup_setup_word_o = core.startup;
  assign latch_loaded_o = core.loaded;

  // ==================================================================
  // reference divider fields
  // a zero divide value is the host's fault and passes unchanged
  assign ref_divide_o = core.reference[`SSL_REF_DIV_LSB +: 14]; // R6 R17
  assign backlash_width_o = core.reference[`SSL_BACKLASH_LSB +: 2]; // R7
  assign test_sel_o = core.reference[`SSL_TEST_SEL_LSB +: 2]; // R8
  assign lock_precision_o = core.reference[`SSL_LOCK_PRECISION_BIT]; // R8

  // ==================================================================
  // feedback divider fields
  assign pump_gain_select_o = core.feedback[`SSL_PUMP_GAIN_BIT]; // R9
  assign main_count_o = core.feedback[`SSL_MAIN_COUNT_LSB +: 13]; // R9
  assign swallow_count_o = core.feedback[`SSL_SWALLOW_LSB +: 6]; // R9

  // ==================================================================
  // function and startup fields
  assign modulus_sel_o = active[`SSL_MODULUS_LSB +: 2]; // R10
  assign power_down_two_o = active[`SSL_POWER_DOWN_TWO_BIT]; // R10
  assign pump_current_b_o = active[`SSL_CURRENT_B_LSB +: 3]; // R10
  assign pump_current_a_o = active[`SSL_CURRENT_A_LSB +: 3]; // R10
  assign fastlock_timer_o = active[`SSL_FASTLOCK_TIMER_LSB +: 4]; // R10
  assign fastlock_mode_o = active[`SSL_FASTLOCK_MODE_BIT]; // R11
  assign fastlock_enable_o = active[`SSL_FASTLOCK_ENABLE_BIT]; // R11
  assign pump_tristate_o = active[`SSL_PUMP_TRISTATE_BIT]; // R11
  assign phase_polarity_o = active[`SSL_PHASE_POLARITY_BIT]; // R11
  assign output_select_o = osel; // R12
  assign power_down_one_o = active[`SSL_POWER_DOWN_ONE_BIT]; // R11
  assign divider_reset_o = active[`SSL_DIVIDER_RESET_BIT]; // R11

  // ==================================================================
  // lock and test outputs
  assign digital_lock_o = lock_flag; // R13
  assign multiplexed_test_output_o = core.mux_out; // R12
endmodule
`default_nettype wire

// ===== common/ssl_cfg.svh
// field positions, reset values and timing counts of the serial latches
`ifndef SSL_CFG_SVH
`define SSL_CFG_SVH
// ==================================================================
// word and select
`define SSL_WORD_W 24
`define SSL_SEL_LSB 0
`define SSL_WORD_RESET 24'h000000
// ==================================================================
// reference divider word
`define SSL_REF_DIV_LSB 2
`define SSL_BACKLASH_LSB 16
`define SSL_TEST_SEL_LSB 18
`define SSL_LOCK_PRECISION_BIT 20
// ==================================================================
// feedback divider word
`define SSL_SWALLOW_LSB 2
`define SSL_MAIN_COUNT_LSB 8
`define SSL_PUMP_GAIN_BIT 21
// ==================================================================
// function and startup words
`define SSL_DIVIDER_RESET_BIT 2
`define SSL_POWER_DOWN_ONE_BIT 3
`define SSL_OUTPUT_SEL_LSB 4
`define SSL_PHASE_POLARITY_BIT 7
`define SSL_PUMP_TRISTATE_BIT 8
`define SSL_FASTLOCK_ENABLE_BIT 9
`define SSL_FASTLOCK_MODE_BIT 10
`define SSL_FASTLOCK_TIMER_LSB 11
`define SSL_CURRENT_A_LSB 15
`define SSL_CURRENT_B_LSB 18
`define SSL_POWER_DOWN_TWO_BIT 21
`define SSL_MODULUS_LSB 22
// ==================================================================
// output select codes
`define SSL_OSEL_LOW 3'h0
`define SSL_OSEL_DIGITAL_LOCK 3'h1
`define SSL_OSEL_FEEDBACK_DIV 3'h2
`define SSL_OSEL_HIGH 3'h3
`define SSL_OSEL_REF_DIV 3'h4
`define SSL_OSEL_ANALOG_LOCK 3'h5
// ==================================================================
// lock detector, thresholds in ns
`define SSL_ENTRY_NS 8'h0F
`define SSL_EXIT_NS 8'h19
`define SSL_LOOSE_CYCLES 3'h3
`define SSL_TIGHT_CYCLES 3'h5
`endif

// ===== common/ssl_pkg.sv
// types shared by the serial latch and lock detect block
`include "ssl_cfg.svh"
package ssl_pkg;
  typedef enum logic [1:0] {
    ssl_sel_reference,
    ssl_sel_feedback,
    ssl_sel_function,
    ssl_sel_startup
  } ssl_latch_e;
  typedef struct packed {
    logic [`SSL_WORD_W-1:0] shift;
  } ssl_link_s;
  typedef struct packed {
    logic load_prev;
    logic use_startup;
    logic [3:0] loaded;
    logic mux_out;
    logic [`SSL_WORD_W-1:0] reference;
    logic [`SSL_WORD_W-1:0] feedback;
    logic [`SSL_WORD_W-1:0] function_w;
    logic [`SSL_WORD_W-1:0] startup;
  } ssl_core_s;
  typedef struct packed {
    logic [2:0] good;
    logic locked;
  } ssl_lock_s;
  typedef struct packed {
    logic [2:0] stages;
    logic level;
  } ssl_sync_s;
endpackage

// ===== verilog/ssl_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ssl_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);
  ssl_pkg::ssl_sync_s st;
  ssl_pkg::ssl_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.stages = {st.stages[1:0], pin_i};
    // stage 0 only feeds stage 1; the level moves when 1 and 2 agree
    if (st.stages[1] == st.stages[2]) begin
      next_st.level = st.stages[2];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;
endmodule
`default_nettype wire

// ===== verilog/ssl_lock.sv
// digital lock detector counting phase detector cycles
`timescale 1ns/100ps
`default_nettype none
`include "ssl_cfg.svh"
module ssl_lock #(
  parameter int ERR_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pd_cycle_i,
  input wire logic [ERR_W-1:0] phase_error_ns_i,
  input wire logic lock_precision_i,
  output logic digital_lock_o
);
  ssl_pkg::ssl_lock_s st;
  ssl_pkg::ssl_lock_s next_st;
  logic [2:0] need;
  logic small_err;
  logic large_err;

  if (ERR_W < 5) begin : g_chk
    $error("ssl_lock: ERR_W too narrow for the exit threshold");
  end

  assign need = lock_precision_i ? `SSL_TIGHT_CYCLES : `SSL_LOOSE_CYCLES; // R14 R15
  assign small_err = phase_error_ns_i < ERR_W'(`SSL_ENTRY_NS);
  assign large_err = phase_error_ns_i > ERR_W'(`SSL_EXIT_NS);

  always_comb begin
    next_st = st;
    if (pd_cycle_i) begin
      if (st.locked) begin
        // between 15 and 25 ns the lock holds
        if (large_err) begin
          next_st.locked = 1'b0; // R16
          next_st.good = 3'h0;
        end
      end else if (!small_err) begin
        next_st.good = 3'h0; // R19
      end else if (st.good + 3'h1 >= need) begin
        next_st.locked = 1'b1; // R14 R15
        next_st.good = 3'h0;
      end else begin
        next_st.good = st.good + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign digital_lock_o = st.locked; // R13
endmodule
`default_nettype wire

// ===== testbench/ssl_top_assertions.sv
// checker of the serial latch and lock detect block
`timescale 1ns/100ps
`default_nettype none
module ssl_top_assertions #(
  parameter int WORD_W = 24,
  parameter int ERR_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pd_cycle_i,
  input wire logic [ERR_W-1:0] phase_error_ns_i,
  input wire logic [WORD_W-1:0] reference_divider_word_o,
  input wire logic [WORD_W-1:0] feedback_divider_word_o,
  input wire logic [3:0] latch_loaded_o,
  input wire logic [13:0] ref_divide_o,
  input wire logic [2:0] output_select_o,
  input wire logic digital_lock_o,
  input wire logic multiplexed_test_output_o
);
  // ==================================================================
  // properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic bad;
  assign bad = pd_cycle_i && phase_error_ns_i > 25;
  a_load_onehot: assert property ($onehot0(latch_loaded_o))
    else $error("two latches loaded at once");
  a_load_pulse: assert property (|latch_loaded_o |=> !latch_loaded_o)
    else $error("load pulse too long");
  a_sel_ref: assert property (latch_loaded_o[0] |->
    reference_divider_word_o[1:0] == 2'h0) else $error("ref select");
  a_sel_fb: assert property (latch_loaded_o[1] |->
    feedback_divider_word_o[1:0] == 2'h1) else $error("fb select");
  a_ref_keep: assert property (!latch_loaded_o[0] |->
    $stable(reference_divider_word_o)) else $error("ref word moved");
  a_fb_keep: assert property (!latch_loaded_o[1] |->
    $stable(feedback_divider_word_o)) else $error("fb word moved");
  a_ref_slice: assert property (ref_divide_o ==
    reference_divider_word_o[15:2]) else $error("ref divide slice");
  a_lock_rise: assert property ($rose(digital_lock_o) |->
    $past(pd_cycle_i) && $past(phase_error_ns_i) < 15)
    else $error("lock rose without good cycle");
  a_lock_drop: assert property (digital_lock_o && bad |=>
    !digital_lock_o) else $error("lock kept after large error");
  a_lock_hold: assert property (digital_lock_o && !bad |=>
    digital_lock_o) else $error("lock lost without large error");
  a_mux_lock: assert property ($past(output_select_o) == 3'h1 |->
    multiplexed_test_output_o == $past(digital_lock_o))
    else $error("mux not showing lock");
  c_startup: cover property (latch_loaded_o[3]);
  c_lock_on: cover property ($rose(digital_lock_o));
  c_lock_off: cover property ($fell(digital_lock_o));
endmodule
bind ssl_top ssl_top_assertions #(.WORD_W(WORD_W), .ERR_W(ERR_W)) u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .pd_cycle_i(pd_cycle_i),
  .phase_error_ns_i(phase_error_ns_i),
  .reference_divider_word_o(reference_divider_word_o),
  .feedback_divider_word_o(feedback_divider_word_o),
  .latch_loaded_o(latch_loaded_o), .ref_divide_o(ref_divide_o),
  .output_select_o(output_select_o), .digital_lock_o(digital_lock_o),
  .multiplexed_test_output_o(multiplexed_test_output_o));
`default_nettype wire

// ===== testbench/ssl_host.sv
// host model shifting words into the serial latches
`timescale 1ns/100ps
`default_nettype none
module ssl_host (
  output logic serial_clock_o,
  output logic serial_data_o,
  output logic load_strobe_o
);
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  // serial clock only runs inside a frame
  task automatic send_word(input logic [23:0] w);
    #13;
    for (int k = 23; k >= 0; k--) begin
      serial_data_o = w[k];
      #40 serial_clock_o = 1'b1;
      #40 serial_clock_o = 1'b0;
    end
    // released line shows the inverse, never the stale bit
    serial_data_o = ~w[0];
    #20 load_strobe_o = 1'b1;
    #160 load_strobe_o = 1'b0;
    #160;
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench of the serial latches and lock detector
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end
module testbench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic pd_cycle_i = 1'b0;
  logic [7:0] phase_error_ns_i = 8'h00;
  logic ref_div_out_i = 1'b0;
  logic feedback_div_out_i = 1'b0;
  logic analog_lock_i = 1'b0;
  wire sclk, sdat, lstb, lock, mux;
  wire [23:0] w0, w1, w2, w3;
  wire [3:0] loaded;
  wire [18:0] rff;
  wire [19:0] fbf;
  wire [21:0] fnf;
  logic [23:0] ex [4];
  logic [23:0] w;
  logic [3:0] seen;
  int act = 2;
  int n;
  int miscompares = 0;
  int n_tests = 0;
  ssl_top DUT (
    .clock_i(clock_i), .rst_i(rst_i), .serial_clock_i(sclk),
    .serial_data_i(sdat), .load_strobe_i(lstb), .pd_cycle_i(pd_cycle_i),
    .phase_error_ns_i(phase_error_ns_i), .ref_div_out_i(ref_div_out_i),
    .feedback_div_out_i(feedback_div_out_i), .analog_lock_i(analog_lock_i),
    .reference_divider_word_o(w0), .feedback_divider_word_o(w1),
    .function_word_o(w2), .startup_setup_word_o(w3),
    .latch_loaded_o(loaded), .ref_divide_o(rff[13:0]),
    .backlash_width_o(rff[15:14]), .test_sel_o(rff[17:16]),
    .lock_precision_o(rff[18]), .pump_gain_select_o(fbf[19]),
    .main_count_o(fbf[18:6]), .swallow_count_o(fbf[5:0]),
    .modulus_sel_o(fnf[21:20]), .power_down_two_o(fnf[19]),
    .pump_current_b_o(fnf[18:16]), .pump_current_a_o(fnf[15:13]),
    .fastlock_timer_o(fnf[12:9]), .fastlock_mode_o(fnf[8]),
    .fastlock_enable_o(fnf[7]), .pump_tristate_o(fnf[6]),
    .phase_polarity_o(fnf[5]), .output_select_o(fnf[4:2]),
    .power_down_one_o(fnf[1]), .divider_reset_o(fnf[0]),
    .digital_lock_o(lock), .multiplexed_test_output_o(mux));
  ssl_host host (.serial_clock_o(sclk), .serial_data_o(sdat),
    .load_strobe_o(lstb));
  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) if (loaded !== 4'h0) seen <= loaded;
  function automatic logic mux_exp(input logic [2:0] c, input logic l);
    case (c)
      3'h1: mux_exp = l;
      3'h2: mux_exp = feedback_div_out_i;
      3'h3: mux_exp = 1'b1;
      3'h4: mux_exp = ref_div_out_i;
      3'h5: mux_exp = analog_lock_i;
      default: mux_exp = 1'b0;
    endcase
  endfunction
  task check_all;
    `CHK("ref word", ex[0], w0)
    `CHK("fb word", ex[1], w1)
    `CHK("fn word", ex[2], w2)
    `CHK("st word", ex[3], w3)
    `CHK("ref fields", ex[0][20:2], rff)
    `CHK("fb fields", ex[1][21:2], fbf)
    `CHK("fn fields", ex[act][23:2], fnf)
    `CHK("mux", mux_exp(ex[act][6:4], 1'b0), mux)
  endtask
  task load(input logic [1:0] s, input logic [23:0] v);
    @(posedge clock_i);
    {ref_div_out_i, feedback_div_out_i, analog_lock_i} <= 3'($urandom);
    seen <= 4'h0;
    ex[s] = {v[23:2], s};
    if (s[1]) act = s;
    host.send_word(ex[s]);
    `CHK("loaded", 4'h1 << s, seen)
    check_all;
  endtask
  task pulse(input logic [7:0] e, input logic l);
    @(posedge clock_i);
    pd_cycle_i <= 1'b1;
    phase_error_ns_i <= e;
    @(posedge clock_i);
    pd_cycle_i <= 1'b0;
    @(posedge clock_i);
    #1;
    `CHK("lock", l, lock)
    `CHK("mux lock", l, mux)
  endtask
  task end_sim;
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hc97d));
    ex = '{default: 24'h000000};
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    check_all;
    for (int i = 0; i < 16; i++) begin
      w = 24'($urandom);
      w[6:4] = {i[3], i[2], i[0]};
      if (i[1:0] == 2'h0) begin
        w[22:21] = 2'h0;
        w[15:2] = (i == 0) ? 14'h3FFF : (i == 4) ? 14'h0001 :
          14'(($urandom % 16383) + 1);
      end
      if (i[1:0] == 2'h1)
        w[20:8] = (i == 1) ? 13'h0003 : (i == 5) ? 13'h1FFF :
          13'(($urandom % 8189) + 3);
      load(i[1:0], w);
    end
    load(2'h2, 24'h000010);
    for (int p = 0; p < 2; p++) begin
      n = p ? 5 : 3;
      load(2'h0, {3'h0, p[0], 18'h00001, 2'h0});
      repeat (n - 1) pulse(8'h05, 1'b0);
      pulse(8'h0F, 1'b0);
      repeat (n - 1) pulse(8'h0E, 1'b0);
      pulse(8'h00, 1'b1);
      pulse(8'h19, 1'b1);
      pulse(8'h1A, 1'b0);
    end
    // reset in mid-run clears every latch and the active choice
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    ex = '{default: 24'h000000};
    act = 2;
    repeat (3) @(posedge clock_i);
    #1;
    check_all;
    load(2'h1, 24'($urandom));
    end_sim;
  end
endmodule
`default_nettype wire
